// [include/uoc_pkg.sv]
// shared constants and carrier types of the otg pipe/endpoint core
package uoc_pkg;

    // ****************************************
    // payload memory and pipe resources
    // ****************************************
    localparam int            RAM_BYTES    = 960;
    localparam int            RAM_ADDR_W   = 10;
    localparam int            PIPE_COUNT   = 7;
    localparam int            SUM_W        = 11;
    localparam logic [8:0]    SMALL_MAX    = 9'h040;
    localparam logic [8:0]    LARGE_MAX    = 9'h100;
    localparam logic [2:0]    FIRST_LARGE  = 3'h5;
    localparam logic [2:0]    CONTROL_PIPE = 3'h0;

    // ****************************************
    // bit timing: sys clock rate and link bit rates
    // ****************************************
    localparam longint        SYS_CLK_KHZ   = 250000;
    localparam longint        FULL_KBPS     = 12000;
    localparam longint        LOW_KBPS      = 1500;
    localparam int            NCO_W         = 16;
    localparam logic [15:0]   NCO_FULL_INC  = 16'((FULL_KBPS * (64'h1 << NCO_W)) / SYS_CLK_KHZ);
    localparam logic [15:0]   NCO_LOW_INC   = 16'((LOW_KBPS * (64'h1 << NCO_W)) / SYS_CLK_KHZ);
    localparam logic [15:0]   NCO_MID_PHASE = 16'h8000;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0]
    {
        XFER_CONTROL = 2'b00,
        XFER_ISO     = 2'b01,
        XFER_BULK    = 2'b10,
        XFER_INTR    = 2'b11
    } uoc_xfer_type;

    typedef enum logic [1:0]
    {
        ROLE_OFF    = 2'b00,
        ROLE_DEVICE = 2'b01,
        ROLE_HOST   = 2'b10
    } uoc_role_type;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed
    {
        logic         alloc;
        logic         double_bank;
        uoc_xfer_type xfer;
        logic [8:0]   size;
    } uoc_pipe_cfg_type;

    typedef uoc_pipe_cfg_type [PIPE_COUNT-1:0] uoc_pipe_table_type;

    typedef struct packed
    {
        logic       req;
        logic       we;
        logic       release_bank;
        logic [2:0] pipe;
        logic [7:0] offset;
        logic [7:0] wdata;
    } uoc_access_type;

    typedef struct packed
    {
        logic       done;
        logic       refused;
        logic [7:0] rdata;
    } uoc_answer_type;

endpackage

// [core/uoc_bit_recover.sv]
// digital clock recovery loop and transmit bit pacing from the sys clock
`timescale 1ns/1ps
module uoc_bit_recover
    import uoc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic enable,
    input  wire logic low_speed,
    // synchronised line
    input  wire logic line_dp,
    input  wire logic line_dm,
    // recovered bits and transmit pacing
    output logic      rx_valid,
    output logic      rx_dp,
    output logic      rx_dm,
    output logic      tx_tick
);

    typedef struct packed
    {
        logic [15:0] rx_phase;
        logic [15:0] tx_phase;
        logic        prev_dp;
        logic        rx_valid;
        logic        rx_dp;
        logic        rx_dm;
        logic        tx_tick;
    } uoc_rec_state_type;

    uoc_rec_state_type state;
    uoc_rec_state_type next_state;

    // ****************************************
    // phase tracking
    // ****************************************
    always_comb
    begin
        logic [15:0] inc;
        logic [16:0] rx_sum;
        logic [16:0] tx_sum;
        inc    = low_speed ? NCO_LOW_INC : NCO_FULL_INC;
        rx_sum = {1'b0, state.rx_phase} + {1'b0, inc};
        tx_sum = {1'b0, state.tx_phase} + {1'b0, inc};
        next_state          = state;
        next_state.prev_dp  = line_dp;
        next_state.rx_valid = 1'b0;
        next_state.tx_tick  = 1'b0;
        if (!enable)
        begin
            next_state.rx_phase = '0;
            next_state.tx_phase = '0;
        end
        else
        begin
            // every edge on line_dp pulls the sample point to mid-bit, so jitter
            // never accumulates across a packet
            if (line_dp != state.prev_dp)
            begin
                next_state.rx_phase = NCO_MID_PHASE;
            end
            else
            begin
                next_state.rx_phase = rx_sum[15:0];
                if (rx_sum[16])
                begin
                    next_state.rx_valid = 1'b1;
                    next_state.rx_dp    = line_dp;
                    next_state.rx_dm    = line_dm;
                end
            end
            next_state.tx_phase = tx_sum[15:0];
            next_state.tx_tick  = tx_sum[16];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rx_valid = state.rx_valid;
    assign rx_dp    = state.rx_dp;
    assign rx_dm    = state.rx_dm;
    assign tx_tick  = state.tx_tick;

endmodule

// [core/uoc_core.sv]
// otg pipe/endpoint core: roles, pins, banked payload ram, bit recovery
`timescale 1ns/1ps
module uoc_core
    import uoc_pkg::*;
#(
    parameter int RAM_SIZE = RAM_BYTES,
    parameter int PIPES    = PIPE_COUNT
)
(
    // clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RST_N,
    // control levels
    input  wire logic               ENABLE,
    input  wire logic               LOW_SPEED,
    input  wire logic               BUS_POWER_SWITCH_POLARITY,
    input  wire logic               BUS_POWER_REQUEST,
    input  wire logic               IFACE_CLOCK_STOP_REQ,
    input  wire logic               IRQ_ACK,
    // pipe configuration
    input  wire logic               CFG_WE,
    input  wire logic [2:0]         CFG_PIPE,
    input  wire uoc_pipe_cfg_type   CFG_DATA,
    output logic                    CFG_ERR,
    // engine and cpu side payload access
    input  wire uoc_access_type     ENG_REQ,
    output uoc_answer_type          ENG_ANS,
    input  wire uoc_access_type     CPU_REQ,
    output uoc_answer_type          CPU_ANS,
    // line pins
    input  wire logic               DP_IN,
    input  wire logic               DM_IN,
    input  wire logic               TX_DRIVE,
    input  wire logic               TX_DP,
    input  wire logic               TX_DM,
    output logic                    DP_OUT,
    output logic                    DM_OUT,
    output logic                    LINE_OE_N,
    output logic                    RX_VALID,
    output logic                    RX_DP,
    output logic                    RX_DM,
    output logic                    TX_TICK,
    // power and plug pins
    input  wire logic               BUS_SUPPLY_SENSE_IN,
    input  wire logic               PLUG_IDENTIFY_IN,
    output logic                    BUS_POWER_SWITCH_OUT,
    // status
    output uoc_role_type            ROLE,
    output logic                    ID_STATUS,
    output logic                    SUPPLY_STATUS,
    output logic                    IFACE_CLOCK_ON,
    output logic                    IRQ
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (RAM_SIZE < 1 || RAM_SIZE > (1 << RAM_ADDR_W))
    begin : g_ram_check
        $error("RAM_SIZE does not fit the payload address width");
    end
    if (PIPES != PIPE_COUNT)
    begin : g_pipe_check
        $error("PIPES must equal the fixed pipe count");
    end

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [8:0] pipe_max(input logic [2:0] p);
        pipe_max = (p >= FIRST_LARGE) ? LARGE_MAX : SMALL_MAX;
    endfunction

    function automatic logic [SUM_W-1:0] pipe_bytes(input uoc_pipe_cfg_type c);
        logic [SUM_W-1:0] s;
        s = {2'h0, c.size};
        pipe_bytes = !c.alloc ? '0 : (c.double_bank ? SUM_W'(s << 1) : s);
    endfunction

    // pipes are packed in ascending order, so a base is the sum below it
    function automatic logic [SUM_W-1:0] pipe_base(input uoc_pipe_table_type t,
                                                   input logic [2:0] p);
        logic [SUM_W-1:0] sum;
        sum = '0;
        for (int i = 0; i < PIPE_COUNT; i++)
        begin
            if (3'(i) < p)
            begin
                sum = sum + pipe_bytes(t[i]);
            end
        end
        pipe_base = sum;
    endfunction

    function automatic logic cfg_legal(input logic [2:0] p, input uoc_pipe_cfg_type c);
        logic ok;
        ok = (c.size != 9'h000) && (c.size <= pipe_max(p));
        if (p == CONTROL_PIPE)
        begin
            ok = ok && (c.xfer == XFER_CONTROL) && !c.double_bank;
        end
        if (c.xfer == XFER_ISO)
        begin
            ok = ok && c.double_bank;
        end
        cfg_legal = ok;
    endfunction

    // ****************************************
    // state
    // ****************************************
    typedef struct packed
    {
        logic [2:0]         sync_dp, sync_dm, sync_id, sync_vbus;
        uoc_pipe_table_type cfg;
        logic [6:0]         eng_sel, cpu_sel, bank0_cpu, bank1_cpu;
        uoc_role_type       role;
        logic               id_status, supply, irq, cfg_err, clk_on, pwr_out;
        uoc_answer_type     eng_ans, cpu_ans;
        logic               dp_out, dm_out, oe_n;
    } uoc_core_state_type;

    uoc_core_state_type state;
    uoc_core_state_type next_state;
    logic [7:0]         ram [RAM_SIZE];
    logic               ram_eng_we;
    logic               ram_cpu_we;
    logic [RAM_ADDR_W-1:0] ram_eng_addr;
    logic [RAM_ADDR_W-1:0] ram_cpu_addr;
    logic               rx_valid_w, rx_dp_w, rx_dm_w, tx_tick_w;

    // ****************************************
    // behaviour
    // ****************************************
    always_comb
    begin
        uoc_pipe_table_type trial;
        logic [SUM_W-1:0]   total;
        logic               enabled, eb, cb, eng_ok, cpu_ok;
        logic [SUM_W-1:0]   ea, ca;
        uoc_pipe_cfg_type   ec, cc;
        trial = state.cfg;
        total = '0;
        {enabled, eb, cb, eng_ok, cpu_ok, ea, ca, ec, cc} = '0;
        next_state = state;
        // synchronisers: bit 0 is read only by bit 1
        next_state.sync_dp   = {state.sync_dp[1:0], DP_IN};
        next_state.sync_dm   = {state.sync_dm[1:0], DM_IN};
        next_state.sync_id   = {state.sync_id[1:0], PLUG_IDENTIFY_IN};
        next_state.sync_vbus = {state.sync_vbus[1:0], BUS_SUPPLY_SENSE_IN};
        enabled = ENABLE;
        // identify and supply status track their pins even while disabled
        next_state.id_status = state.sync_id[1];
        next_state.supply    = state.sync_vbus[1];
        next_state.clk_on    = !(IFACE_CLOCK_STOP_REQ && !enabled);
        // one request line: any identify or supply change; a new event beats ack
        next_state.irq = (state.irq && !IRQ_ACK)
                       || (state.sync_id[2] != state.sync_id[1])
                       || (state.sync_vbus[2] != state.sync_vbus[1]);
        if (!enabled)
        begin
            next_state.role = ROLE_OFF;
        end
        else
        begin
            next_state.role = state.sync_id[1] ? ROLE_DEVICE : ROLE_HOST;
        end
        next_state.pwr_out = (BUS_POWER_REQUEST && state.role == ROLE_HOST)
                           == BUS_POWER_SWITCH_POLARITY;
        // pipe configuration, refused when illegal or over the ram budget
        next_state.cfg_err = 1'b0;
        if (CFG_WE && CFG_PIPE < 3'(PIPE_COUNT))
        begin
            trial[CFG_PIPE] = CFG_DATA;
            for (int i = 0; i < PIPE_COUNT; i++)
            begin
                total = total + pipe_bytes(trial[i]);
            end
            if (cfg_legal(CFG_PIPE, CFG_DATA) && total <= SUM_W'(RAM_SIZE))
            begin
                next_state.cfg[CFG_PIPE]       = CFG_DATA;
                next_state.eng_sel[CFG_PIPE]   = 1'b0;
                next_state.cpu_sel[CFG_PIPE]   = 1'b0;
                next_state.bank0_cpu[CFG_PIPE] = 1'b0;
                next_state.bank1_cpu[CFG_PIPE] = 1'b0;
            end
            else
            begin
                next_state.cfg_err = 1'b1;
            end
        end
        else if (CFG_WE)
        begin
            next_state.cfg_err = 1'b1;
        end
        // engine side: only its own bank, only while enabled
        ec = state.cfg[ENG_REQ.pipe];
        eb = state.eng_sel[ENG_REQ.pipe];
        eng_ok = enabled && ENG_REQ.req && ENG_REQ.pipe < 3'(PIPE_COUNT) && ec.alloc
               && !(eb ? state.bank1_cpu[ENG_REQ.pipe] : state.bank0_cpu[ENG_REQ.pipe])
               && (ENG_REQ.release_bank || {1'b0, ENG_REQ.offset} < ec.size);
        ea = pipe_base(state.cfg, ENG_REQ.pipe) + (eb ? {2'h0, ec.size} : '0)
           + {3'h0, ENG_REQ.offset};
        // cpu side: only banks handed over by the engine
        cc = state.cfg[CPU_REQ.pipe];
        cb = state.cpu_sel[CPU_REQ.pipe];
        cpu_ok = CPU_REQ.req && CPU_REQ.pipe < 3'(PIPE_COUNT) && cc.alloc
               && (cb ? state.bank1_cpu[CPU_REQ.pipe] : state.bank0_cpu[CPU_REQ.pipe])
               && (CPU_REQ.release_bank || {1'b0, CPU_REQ.offset} < cc.size);
        ca = pipe_base(state.cfg, CPU_REQ.pipe) + (cb ? {2'h0, cc.size} : '0)
           + {3'h0, CPU_REQ.offset};
        ram_eng_addr = ea[RAM_ADDR_W-1:0];
        ram_cpu_addr = ca[RAM_ADDR_W-1:0];
        ram_eng_we   = eng_ok && ENG_REQ.we && !ENG_REQ.release_bank;
        ram_cpu_we   = cpu_ok && CPU_REQ.we && !CPU_REQ.release_bank;
        next_state.eng_ans = '{done: eng_ok, refused: ENG_REQ.req && !eng_ok,
                               rdata: ram[ram_eng_addr]};
        next_state.cpu_ans = '{done: cpu_ok, refused: CPU_REQ.req && !cpu_ok,
                               rdata: ram[ram_cpu_addr]};
        // outside a pipe write or disable, a bank changes hands only when its present owner lets it go
        if (eng_ok && ENG_REQ.release_bank)
        begin
            if (eb)
            begin
                next_state.bank1_cpu[ENG_REQ.pipe] = 1'b1;
            end
            else
            begin
                next_state.bank0_cpu[ENG_REQ.pipe] = 1'b1;
            end
            next_state.eng_sel[ENG_REQ.pipe] = eb ^ ec.double_bank;
        end
        if (cpu_ok && CPU_REQ.release_bank)
        begin
            if (cb)
            begin
                next_state.bank1_cpu[CPU_REQ.pipe] = 1'b0;
            end
            else
            begin
                next_state.bank0_cpu[CPU_REQ.pipe] = 1'b0;
            end
            next_state.cpu_sel[CPU_REQ.pipe] = cb ^ cc.double_bank;
        end
        // line drive: full/low speed only; no chirp path exists
        if (!enabled)
        begin
            next_state.oe_n = 1'b1;
        end
        else if (tx_tick_w)
        begin
            next_state.oe_n   = !TX_DRIVE;
            next_state.dp_out = TX_DP;
            next_state.dm_out = TX_DM;
        end
        // disabling acts as a reset of pipes and ownership; ram is kept
        if (!enabled)
        begin
            next_state.cfg       = '0;
            next_state.eng_sel   = '0;
            next_state.cpu_sel   = '0;
            next_state.bank0_cpu = '0;
            next_state.bank1_cpu = '0;
            next_state.cfg_err   = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state        <= '0;
            state.oe_n   <= 1'b1;
            state.clk_on <= 1'b1;
            state.sync_id   <= 3'h7;
            state.id_status <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    // payload ram keeps its content through reset; banks never collide
    always_ff @(posedge SYS_CLK)
    begin
        if (ram_eng_we)
        begin
            ram[ram_eng_addr] <= ENG_REQ.wdata;
        end
        if (ram_cpu_we)
        begin
            ram[ram_cpu_addr] <= CPU_REQ.wdata;
        end
    end

    // ****************************************
    // bit recovery
    // ****************************************
    uoc_bit_recover u_recover
    (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .enable    (state.role != ROLE_OFF),
        .low_speed (LOW_SPEED),
        .line_dp   (state.sync_dp[1]),
        .line_dm   (state.sync_dm[1]),
        .rx_valid  (rx_valid_w),
        .rx_dp     (rx_dp_w),
        .rx_dm     (rx_dm_w),
        .tx_tick   (tx_tick_w)
    );

    assign RX_VALID             = rx_valid_w;
    assign RX_DP                = rx_dp_w;
    assign RX_DM                = rx_dm_w;
    assign TX_TICK              = tx_tick_w;
    assign CFG_ERR              = state.cfg_err;
    assign ENG_ANS              = state.eng_ans;
    assign CPU_ANS              = state.cpu_ans;
    assign DP_OUT               = state.dp_out;
    assign DM_OUT               = state.dm_out;
    assign LINE_OE_N            = state.oe_n;
    assign BUS_POWER_SWITCH_OUT = state.pwr_out;
    assign ROLE                 = state.role;
    assign ID_STATUS            = state.id_status;
    assign SUPPLY_STATUS        = state.supply;
    assign IFACE_CLOCK_ON       = state.clk_on;
    assign IRQ                  = state.irq;

endmodule

// [sim/uoc_core_asserts.sv]
// port checker for the otg pipe/endpoint core
`timescale 1ns/1ps
module uoc_core_asserts
    import uoc_pkg::*;
(
    // clock, reset and controls
    input wire logic           SYS_CLK,
    input wire logic           RST_N,
    input wire logic           ENABLE,
    input wire logic           LOW_SPEED,
    input wire logic           BUS_POWER_SWITCH_POLARITY,
    input wire logic           BUS_POWER_REQUEST,
    input wire logic           IFACE_CLOCK_STOP_REQ,
    input wire logic           CFG_WE,
    input wire logic           CFG_ERR,
    // access and line
    input wire uoc_access_type ENG_REQ,
    input wire uoc_answer_type ENG_ANS,
    input wire logic           DP_IN,
    input wire logic           TX_DRIVE,
    input wire logic           TX_DP,
    input wire logic           TX_DM,
    input wire logic           TX_TICK,
    input wire logic           DP_OUT,
    input wire logic           DM_OUT,
    input wire logic           LINE_OE_N,
    // pins and status
    input wire logic           PLUG_IDENTIFY_IN,
    input wire logic           BUS_POWER_SWITCH_OUT,
    input wire uoc_role_type   ROLE,
    input wire logic           ID_STATUS,
    input wire logic           IFACE_CLOCK_ON,
    input wire logic           IRQ
);
    // ****
    // tick spacing, judged after a calm stretch: enabling restarts the pacing, a speed change alters its step
    // ****
    logic [7:0] gap;
    logic [8:0] calm;
    logic       low_q;
    logic       dp_q;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            gap   <= '0;
            calm  <= '0;
            low_q <= '0;
            dp_q  <= '0;
        end
        else
        begin
            low_q <= LOW_SPEED;
            dp_q  <= DP_IN;
            gap   <= TX_TICK ? 8'h01 : gap + {7'h00, gap != 8'hFF};
            calm  <= (!ENABLE || LOW_SPEED != low_q || DP_IN != dp_q) ? 9'h000
                     : calm + {8'h00, calm != 9'h1FF};
        end
    end
    a_tick_gap: assert property (TX_TICK && calm > {1'b0, gap} + 9'h008 |->
        (LOW_SPEED ? gap inside {8'hA6, 8'hA7} : gap inside {8'h14, 8'h15}))
        else $error("bit pacing interval off");
    a_power_switch: assert property ($past(RST_N) && $stable(ROLE) &&
        $stable(BUS_POWER_REQUEST) && $stable(BUS_POWER_SWITCH_POLARITY) |->
        BUS_POWER_SWITCH_OUT == ((BUS_POWER_REQUEST && ROLE == ROLE_HOST)
        == BUS_POWER_SWITCH_POLARITY)) else $error("power switch level wrong");
    a_eng_off: assert property (!ENABLE && ENG_REQ.req |=>
        ENG_ANS.refused && !ENG_ANS.done) else $error("disabled engine served");
    a_role_off: assert property (!ENABLE |=> ROLE == ROLE_OFF)
        else $error("role while disabled");
    a_role_dev: assert property ((ENABLE && ID_STATUS)[*3] |-> ROLE == ROLE_DEVICE)
        else $error("device role missing");
    a_role_host: assert property ((ENABLE && !ID_STATUS)[*3] |-> ROLE == ROLE_HOST)
        else $error("host role missing");
    a_answer_cause: assert property (ENG_ANS.done || ENG_ANS.refused |->
        $past(ENG_REQ.req) && !(ENG_ANS.done && ENG_ANS.refused))
        else $error("answer without request");
    a_cfg_err: assert property (CFG_ERR |-> $past(CFG_WE))
        else $error("config error without write");
    a_line_drive: assert property (TX_TICK && ENABLE && TX_DRIVE |=> !LINE_OE_N &&
        DP_OUT == $past(TX_DP) && DM_OUT == $past(TX_DM)) else $error("line not driven");
    a_id_sync: assert property ($stable(PLUG_IDENTIFY_IN)[*4] |->
        ID_STATUS == PLUG_IDENTIFY_IN) else $error("identify status stale");
    a_irq_on_id: assert property ($past(RST_N) && $changed(ID_STATUS) |-> ##[0:2] IRQ)
        else $error("no interrupt on identify change");
    a_clock_hold: assert property ($fell(IFACE_CLOCK_ON) |->
        $past(IFACE_CLOCK_STOP_REQ) && !$past(ENABLE)) else $error("clock dropped early");
endmodule
bind uoc_core uoc_core_asserts u_chk (.*);

// [sim/uoc_line_peer.sv]
// far-end line model: sends one byte on the pair, idles in the J state
`timescale 1ns/1ps
module uoc_line_peer
(
    // clock and control
    input  wire logic       clk,
    input  wire logic       low_speed,
    input  wire logic       go,
    input  wire logic [7:0] data,
    // line
    output logic            dp,
    output logic            dm,
    output logic            busy
);
    logic [7:0] cnt  = '0;
    logic [2:0] bits = '0;
    logic [7:0] shf  = '0;
    initial busy = '0;
    assign dp = busy ? shf[0] : !low_speed;
    assign dm = !dp;
    always @(posedge clk)
    begin
        if (!busy)
        begin
            busy <= go;
            shf  <= data;
            cnt  <= '0;
            bits <= '0;
        end
        else if (cnt == (low_speed ? 8'hA6 : 8'h14))
        begin
            cnt  <= '0;
            shf  <= shf >> 1;
            bits <= bits + 3'h1;
            busy <= bits != 3'h7;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule

// [sim/tb.sv]
// self-checking bench of the otg pipe/endpoint core
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
`define WAITC(c) for (n = 0; n < 400 && (c) !== 1'b1; n++) @(negedge SYS_CLK); \
    if ((c) !== 1'b1) begin err_total++; tally_and_finish(); end
module tb
    import uoc_pkg::*;
;
    // ****
    // stimulus and rows
    // ****
    typedef struct packed {logic [2:0] p; uoc_pipe_cfg_type c; logic e;} uoc_row_type;
    logic SYS_CLK = 0, RST_N = 0, ENABLE = 0, LOW_SPEED = 0, BUS_POWER_SWITCH_POLARITY = 1;
    logic BUS_POWER_REQUEST = 0, IFACE_CLOCK_STOP_REQ = 0, IRQ_ACK = 0, CFG_WE = 0;
    logic TX_DRIVE = 0, TX_DP = 0, TX_DM = 0, BUS_SUPPLY_SENSE_IN = 0, PLUG_IDENTIFY_IN = 1;
    logic [2:0] CFG_PIPE = '0;
    uoc_pipe_cfg_type CFG_DATA = '0;
    uoc_access_type ENG_REQ = '0, CPU_REQ = '0;
    uoc_answer_type ENG_ANS, CPU_ANS;
    uoc_role_type ROLE;
    logic DP_IN, DM_IN, CFG_ERR, DP_OUT, DM_OUT, LINE_OE_N, RX_VALID, RX_DP, RX_DM, TX_TICK;
    logic BUS_POWER_SWITCH_OUT, ID_STATUS, SUPPLY_STATUS, IFACE_CLOCK_ON, IRQ, go = 0, busy;
    logic [7:0] sh;
    int err_total = 0, num_checks = 0, i, n;
    uoc_row_type rows [11] = '{
        {3'h0, 1'b1, 1'b0, XFER_CONTROL, 9'h040, 1'b0}, {3'h0, 1'b1, 1'b0, XFER_BULK, 9'h040, 1'b1},
        {3'h0, 1'b1, 1'b1, XFER_CONTROL, 9'h040, 1'b1}, {3'h1, 1'b1, 1'b0, XFER_BULK, 9'h041, 1'b1},
        {3'h1, 1'b1, 1'b0, XFER_ISO, 9'h040, 1'b1}, {3'h1, 1'b1, 1'b1, XFER_BULK, 9'h040, 1'b0},
        {3'h2, 1'b1, 1'b0, XFER_BULK, 9'h000, 1'b1}, {3'h5, 1'b1, 1'b1, XFER_ISO, 9'h100, 1'b0},
        {3'h6, 1'b1, 1'b1, XFER_INTR, 9'h100, 1'b1}, {3'h6, 1'b1, 1'b0, XFER_INTR, 9'h100, 1'b0},
        {3'h7, 1'b1, 1'b0, XFER_BULK, 9'h040, 1'b1}};
    uoc_core DUT (.*);
    uoc_line_peer PEER (.clk(SYS_CLK), .low_speed(LOW_SPEED), .go(go), .data(8'h5A),
                        .dp(DP_IN), .dm(DM_IN), .busy(busy));
    always #2 SYS_CLK = ~SYS_CLK;
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task acc(input logic c, w, rl, input logic [2:0] p, input logic [7:0] o, d, input logic rf);
        uoc_answer_type a;
        @(posedge SYS_CLK);
        if (c)
            CPU_REQ <= {1'b1, w, rl, p, o, d};
        else
            ENG_REQ <= {1'b1, w, rl, p, o, d};
        @(posedge SYS_CLK);
        CPU_REQ.req <= '0;
        ENG_REQ.req <= '0;
        @(negedge SYS_CLK);
        a = c ? CPU_ANS : ENG_ANS;
        `CHK({a.done, a.refused}, {!rf, rf})
        if (!rf && !w && !rl)
            `CHK(a.rdata, d)
    endtask
    task frame;
        @(posedge SYS_CLK) go <= '1;
        @(posedge SYS_CLK) go <= '0;
        i = 0;
        @(negedge SYS_CLK);
        for (n = 0; n < 2000 && busy; n++)
        begin
            @(negedge SYS_CLK);
            i += RX_VALID;
            if (RX_VALID)
                sh = {RX_DP, sh[7:1]};
        end
        `WAITC(!busy)
        `CHK(i inside {[7:9]}, 1'b1)
        `CHK(sh, 8'h5A)
    endtask
    task pulse_ack;
        @(posedge SYS_CLK) IRQ_ACK <= '1;
        @(posedge SYS_CLK) IRQ_ACK <= '0;
        @(negedge SYS_CLK);
        `CHK(IRQ, 1'b0)
    endtask
    initial
    begin
        @(negedge SYS_CLK) `CHK({ROLE, IFACE_CLOCK_ON, LINE_OE_N}, {ROLE_OFF, 2'b11})
        repeat (2) @(posedge SYS_CLK);
        RST_N <= '1;
        @(posedge SYS_CLK) ENABLE <= '1;
        BUS_POWER_REQUEST <= '1;
        `WAITC(ROLE == ROLE_DEVICE)
        `CHK(BUS_POWER_SWITCH_OUT, 1'b0)
        pulse_ack();
        foreach (rows[k])
        begin
            @(posedge SYS_CLK) {CFG_WE, CFG_PIPE, CFG_DATA} <= {1'b1, rows[k].p, rows[k].c};
            @(posedge SYS_CLK) CFG_WE <= '0;
            @(negedge SYS_CLK) `CHK(CFG_ERR, rows[k].e)
        end
        // ping-pong on pipe 1, single bank on pipe 0, large pipes at the top byte
        acc(1, 0, 0, 1, 8'h00, 8'h00, 1);
        acc(0, 1, 0, 1, 8'h00, 8'hA5, 0);
        acc(0, 1, 0, 1, 8'h3F, 8'h5A, 0);
        acc(0, 1, 0, 1, 8'h40, 8'h00, 1);
        acc(0, 0, 1, 1, 8'h00, 8'h00, 0);
        acc(0, 1, 0, 1, 8'h00, 8'hC3, 0);
        acc(1, 0, 0, 1, 8'h00, 8'hA5, 0);
        acc(1, 0, 0, 1, 8'h3F, 8'h5A, 0);
        acc(0, 0, 1, 1, 8'h00, 8'h00, 0);
        acc(0, 1, 0, 1, 8'h00, 8'h11, 1);
        acc(1, 0, 1, 1, 8'h00, 8'h00, 0);
        acc(1, 0, 0, 1, 8'h00, 8'hC3, 0);
        acc(0, 1, 0, 1, 8'h00, 8'h11, 0);
        acc(0, 0, 0, 1, 8'h00, 8'h11, 0);
        acc(0, 1, 0, 0, 8'h00, 8'h77, 0);
        acc(0, 0, 1, 0, 8'h00, 8'h00, 0);
        acc(0, 1, 0, 0, 8'h00, 8'h88, 1);
        acc(1, 0, 0, 0, 8'h00, 8'h77, 0);
        acc(1, 0, 0, 2, 8'h00, 8'h00, 1);
        acc(0, 1, 0, 5, 8'hFF, 8'h99, 0);
        acc(0, 1, 0, 6, 8'hFF, 8'h66, 0);
        acc(0, 0, 1, 6, 8'h00, 8'h00, 0);
        acc(1, 0, 0, 6, 8'hFF, 8'h66, 0);
        frame();
        {TX_DRIVE, TX_DP, TX_DM} <= 3'b110;
        `WAITC(TX_TICK)
        @(negedge SYS_CLK) `CHK({LINE_OE_N, DP_OUT}, 2'b01)
        @(posedge SYS_CLK) LOW_SPEED <= '1;
        frame();
        @(posedge SYS_CLK) PLUG_IDENTIFY_IN <= '0;
        `WAITC(ROLE == ROLE_HOST)
        @(negedge SYS_CLK);
        `CHK({ID_STATUS, IRQ, BUS_POWER_SWITCH_OUT}, 3'b011)
        @(posedge SYS_CLK) BUS_POWER_SWITCH_POLARITY <= '0;
        pulse_ack();
        `CHK(BUS_POWER_SWITCH_OUT, 1'b0)
        @(posedge SYS_CLK) BUS_SUPPLY_SENSE_IN <= '1;
        repeat (4) @(negedge SYS_CLK);
        `CHK({SUPPLY_STATUS, IRQ}, 2'b11)
        @(posedge SYS_CLK) {ENABLE, IFACE_CLOCK_STOP_REQ} <= 2'b01;
        acc(0, 1, 0, 1, 8'h00, 8'h00, 1);
        `CHK({ROLE, IFACE_CLOCK_ON}, {ROLE_OFF, 1'b0})
        @(posedge SYS_CLK) RST_N <= '0;
        @(negedge SYS_CLK) `CHK({ROLE, IFACE_CLOCK_ON}, {ROLE_OFF, 1'b1})
        @(posedge SYS_CLK) RST_N <= '1;
        tally_and_finish();
    end
endmodule
